// ---- core/can_mode_cfg.svh ----
`ifndef CAN_MODE_CFG_SVH
`define CAN_MODE_CFG_SVH
// Timing constants
`define CLK_MHZ            200
`define TXDOM_LIMIT_US     2000
`define TXDOM_LIMIT_CYC    (`TXDOM_LIMIT_US * `CLK_MHZ)
`define DET_FILT_CYC       32'd2000
`define REC_FILT_CYC       32'd4000
`define WAKE_FILT_CYC      32'd1000
`define L_FAULT_TMO_CYC    32'd2000
// Failure indices (failure n sits at bit n-1)
`define FAIL_H_OPEN        0
`define FAIL_L_OPEN        1
`define FAIL_H_BATT        2
`define FAIL_L_GND         3
`define FAIL_H_GND         4
`define FAIL_L_BATT        5
`define FAIL_SHORT         6
`define FAIL_H_PSUP        7
`define NUM_FAIL           8
// Mode codes as written by software
`define MODE_STBY          3'h0
`define MODE_FULL_STD      3'h1
`define MODE_FULL_EXT      3'h2
`define MODE_RXO_STD       3'h3
`define MODE_RXO_EXT       3'h4
`endif

// ---- core/can_mode_pkg.sv ----
package can_mode_pkg;
  // Effective transceiver mode
  typedef enum logic [1:0]
  {
    XCVR_STBY = 2'b00,
    XCVR_FULL = 2'b01,
    XCVR_RXO  = 2'b10
  } xcvr_mode_t;
  // System controller mode
  typedef enum logic [2:0]
  {
    SYS_NREQ  = 3'b000,
    SYS_NORM  = 3'b001,
    SYS_STBY  = 3'b010,
    SYS_SLEEP = 3'b011,
    SYS_EMERG = 3'b100
  } sys_mode_t;
endpackage : can_mode_pkg

// ---- core/evt_fifo_if.sv ----
`timescale 1ns/10ps
// Event word path into the flag FIFO
interface evt_fifo_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport src  (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
  modport fifo (input in_valid, input in_data, output in_ready,
                output out_valid, output out_data, input out_ready);
endinterface : evt_fifo_if

// ---- core/evt_fifo.sv ----
`timescale 1ns/10ps
// Small synchronous FIFO for failure event words
module evt_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic CLK,   // Clock
  input  wire logic RST,   // Sync reset
  evt_fifo_if.fifo  f      // Event path
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  wire  push = f.in_valid && f.in_ready;
  wire  pop  = f.out_valid && f.out_ready;
  // Full and empty from occupancy count
  assign f.in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign f.out_valid = (cnt_r != '0);
  assign f.out_data  = mem[rp_r];
  // Storage and pointers
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end
    else
    begin
      if (push)
      begin
        mem[wp_r] <= f.in_data;
        wp_r      <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + AW'(1);
      end
      if (pop)
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + AW'(1);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : evt_fifo

// ---- core/can_mode_ctrl.sv ----
`timescale 1ns/10ps
`include "can_mode_cfg.svh"
// Notes on behaviour
// - No failure: RX follows differential receiver
// - RX-only: TX off, RX = TX or bus
// - Failure detection alike in full, RX-only
// - Eight failure types numbered one to eight
// - Failures 3/6 filtered on detect and recover
// - Failures 4/7: low driver, termination off
// - 4/7 recovery after recessive differential filter
// - Failure sets flag, maskable interrupt
// - Recovered flag clears only after read
// - TX dominant over 2 ms disables drivers
// - Over-temperature disables transmitter only
// - Software selects mode; encodings equivalent
// - Full mode: transmit, receive, detection
// - Stand-by: wake plus failures 3,4,7,8
// - Stand-by entered and left by command
// - Low power: dominant wake line wakes
// - Wake: interrupt or normal request; record
// - Wake level must persist filter time
// - Power-up: normal request, bus stand-by
// - Supply undervoltage forces bus stand-by
// - Five system modes supported
// - Switch and driver actions per failure
// - Supply off: stand-by until reconfigured
// - Active modes only in system normal
module can_mode_ctrl #(
  parameter int TXDOM_CYC   = `TXDOM_LIMIT_CYC,
  parameter int DET_CYC     = `DET_FILT_CYC,
  parameter int REC_CYC     = `REC_FILT_CYC,
  parameter int WAKE_CYC    = `WAKE_FILT_CYC,
  parameter int LTMO_CYC    = `L_FAULT_TMO_CYC,
  parameter int FIFO_DEPTH  = 8
) (
  input  wire logic       CLK,           // 200 MHz clock
  input  wire logic       RST,           // Sync reset, power-on
  input  wire logic       TX_DOM,        // Controller transmit dominant
  output logic            RX_DOM,        // Receive dominant to controller
  input  wire logic       DIFF_DOM,      // Differential receiver dominant
  input  wire logic       H_DOM,         // High-wire single receiver dominant
  input  wire logic       DIFF_BELOW_REC,// Differential below recessive threshold
  input  wire logic [7:0] FAIL_CMP,      // Raw failure comparators, bit n-1 = failure n
  input  wire logic       WAKE_H,        // High wake-line dominant
  input  wire logic       WAKE_L,        // Low wake-line dominant
  input  wire logic       OVER_TEMP,     // Junction over-temperature
  input  wire logic       PSUP_UV,       // Peripheral supply undervoltage
  input  wire logic       MODE_WR,       // Control register write strobe
  input  wire logic [2:0] MODE_WDATA,    // Mode code written
  input  wire logic [2:0] SYS_MODE,      // System mode request
  input  wire logic       FLAG_RD,       // Error status read strobe
  input  wire logic       WAKE_RD,       // Wake status read strobe
  input  wire logic [7:0] FAIL_MASK,     // Interrupt enable per failure
  output logic [1:0]      XCVR_MODE,     // Effective transceiver mode
  output logic [2:0]      SYS_STATE,     // System mode
  output logic            H_DRV_EN,      // High driver enable
  output logic            L_DRV_EN,      // Low driver enable
  output logic            H_TERM_GND_ON, // High termination ground switch
  output logic            L_TERM_ON,     // Low termination switches
  output logic            SINGLE_WIRE,   // Single-wire reception active
  output logic [3:0]      ERR_HI,        // Error status high, failures 8..5
  output logic [3:0]      ERR_LO,        // Error status low, failures 4..1
  output logic            WAKE_FLAG,     // Bus wake recorded
  output logic            INT_REQ,       // Interrupt request
  output logic            TXDOM_TMO      // Transmit stuck-dominant flag
);
  localparam int CW = 32;
  // Mode register and system state
  can_mode_pkg::xcvr_mode_t mode_r, mode_nxt;
  can_mode_pkg::sys_mode_t  sys_r,  sys_nxt;
  logic [CW-1:0]            txc_r;
  logic                     txlock_r;
  logic [CW-1:0]            wk_r;
  logic                     wake_r;
  logic [7:0]               act_r;
  logic [7:0]               flag_r;
  logic [7:0]               seen_r;
  logic                     rx_r;
  logic [2:0]               sysreq_r;
  logic [7:0]               fifo_ev;
  evt_fifo_if #(.W(8)) ev ();
  // Mode decode of written code, both encodings equal
  wire wr_full  = (MODE_WDATA == `MODE_FULL_STD) || (MODE_WDATA == `MODE_FULL_EXT);
  wire wr_rxo   = (MODE_WDATA == `MODE_RXO_STD)  || (MODE_WDATA == `MODE_RXO_EXT);
  wire sys_norm = (sys_r == can_mode_pkg::SYS_NORM);
  wire standby  = (mode_r == can_mode_pkg::XCVR_STBY);
  wire rxo      = (mode_r == can_mode_pkg::XCVR_RXO);
  wire fdet_all = !standby;
  // Enable mask: stand-by keeps only failures 3, 4, 7, 8
  wire [7:0] stby_mask = (8'h1 << `FAIL_H_BATT) | (8'h1 << `FAIL_L_GND)
                       | (8'h1 << `FAIL_SHORT)  | (8'h1 << `FAIL_H_PSUP);
  wire [7:0] det_en = fdet_all ? 8'hff : stby_mask;
  // Next transceiver mode
  always_comb
  begin
    mode_nxt = mode_r;
    if (MODE_WR && wr_full)
      mode_nxt = can_mode_pkg::XCVR_FULL;
    else if (MODE_WR && wr_rxo)
      mode_nxt = can_mode_pkg::XCVR_RXO;
    else if (MODE_WR)
      mode_nxt = can_mode_pkg::XCVR_STBY;
    if (PSUP_UV || !sys_norm)
      mode_nxt = can_mode_pkg::XCVR_STBY;
  end
  // Next system mode; bus wake from sleep goes to normal request
  always_comb
  begin
    sys_nxt = sys_r;
    // Only a changed request is taken, so a held level cannot undo a wake
    if (SYS_MODE != sysreq_r && SYS_MODE <= 3'h4)
      sys_nxt = can_mode_pkg::sys_mode_t'(SYS_MODE);
    if (wake_r && sys_r == can_mode_pkg::SYS_SLEEP)
      sys_nxt = can_mode_pkg::SYS_NREQ;
  end
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      mode_r <= can_mode_pkg::XCVR_STBY;
      sys_r  <= can_mode_pkg::SYS_NREQ;
      sysreq_r <= can_mode_pkg::SYS_NREQ;
    end
    else
    begin
      mode_r <= mode_nxt;
      sys_r  <= sys_nxt;
      sysreq_r <= SYS_MODE;
    end
  end
  // Per-failure detect and recover, filtered for failures 3, 4, 6, 7
  genvar g;
  generate
    for (g = 0; g < `NUM_FAIL; g++)
    begin : g_fail
      logic [CW-1:0] cnt_r;
      wire filt  = (g == `FAIL_H_BATT) || (g == `FAIL_L_BATT);
      wire lflt  = (g == `FAIL_L_GND)  || (g == `FAIL_SHORT);
      wire cmp   = FAIL_CMP[g] && det_en[g];
      wire clr_c = lflt ? DIFF_BELOW_REC : !cmp;
      wire [CW-1:0] dlim = lflt ? CW'(LTMO_CYC) : CW'(DET_CYC);
      wire [CW-1:0] rlim = CW'(REC_CYC);
      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          cnt_r    <= '0;
          act_r[g] <= 1'b0;
        end
        else if (!act_r[g])
        begin
          if (!cmp)
            cnt_r <= '0;
          else if (!(filt || lflt) || cnt_r >= dlim - CW'(1))
          begin
            act_r[g] <= 1'b1;
            cnt_r    <= '0;
          end
          else
            cnt_r <= cnt_r + CW'(1);
        end
        else
        begin
          if (!clr_c)
            cnt_r <= '0;
          else if (!(filt || lflt) || cnt_r >= rlim - CW'(1))
          begin
            act_r[g] <= 1'b0;
            cnt_r    <= '0;
          end
          else
            cnt_r <= cnt_r + CW'(1);
        end
      end
      // Sticky flag: set wins, clears after read once recovered
      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          flag_r[g] <= 1'b0;
          seen_r[g] <= 1'b0;
        end
        else if (act_r[g])
        begin
          flag_r[g] <= 1'b1;
          seen_r[g] <= FLAG_RD ? 1'b1 : seen_r[g];
        end
        else
        begin
          seen_r[g] <= (FLAG_RD && flag_r[g]) ? 1'b1 : seen_r[g];
          if (seen_r[g] || FLAG_RD)
          begin
            flag_r[g] <= 1'b0;
            seen_r[g] <= 1'b0;
          end
        end
      end
      assign fifo_ev[g] = act_r[g] && !flag_r[g];
    end
  endgenerate
  // New-failure events queue toward the interrupt
  assign ev.in_valid  = |(fifo_ev & FAIL_MASK);
  assign ev.in_data   = fifo_ev & FAIL_MASK;
  assign ev.out_ready = FLAG_RD;
  evt_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .CLK (CLK),
    .RST (RST),
    .f   (ev)
  );
  // Stuck-dominant transmit timer
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      txc_r    <= '0;
      txlock_r <= 1'b0;
    end
    else if (!TX_DOM)
    begin
      txc_r    <= '0;
      txlock_r <= 1'b0;
    end
    else if (txc_r >= CW'(TXDOM_CYC))
      txlock_r <= 1'b1;
    else
      txc_r <= txc_r + CW'(1);
  end
  // Wake filter, active only in bus stand-by
  wire wake_lvl = standby && (WAKE_H || WAKE_L);
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      wk_r   <= '0;
      wake_r <= 1'b0;
    end
    else
    begin
      wk_r <= wake_lvl ? ((wk_r >= CW'(WAKE_CYC)) ? wk_r : wk_r + CW'(1)) : '0;
      if (wake_lvl && wk_r == CW'(WAKE_CYC - 1))
        wake_r <= 1'b1;
      else if (WAKE_RD)
        wake_r <= 1'b0;
    end
  end
  // Driver and termination control
  wire hfail  = act_r[`FAIL_H_BATT] || act_r[`FAIL_H_PSUP];
  wire lfail  = act_r[`FAIL_L_GND] || act_r[`FAIL_L_BATT] || act_r[`FAIL_SHORT];
  wire tx_ok  = (mode_r == can_mode_pkg::XCVR_FULL) && !txlock_r && !OVER_TEMP;
  wire sw_on  = |act_r[7:1] && fdet_all;
  wire rx_bus = sw_on ? H_DOM : DIFF_DOM;
  // Receive path registered
  always_ff @(posedge CLK)
  begin
    if (RST)
      rx_r <= 1'b0;
    else
      rx_r <= !standby && (rx_bus || (rxo && TX_DOM));
  end
  assign RX_DOM        = rx_r;
  assign XCVR_MODE     = mode_r;
  assign SYS_STATE     = sys_r;
  assign H_DRV_EN      = tx_ok && !hfail;
  assign L_DRV_EN      = tx_ok && !lfail;
  assign H_TERM_GND_ON = !hfail;
  assign L_TERM_ON     = !lfail;
  assign SINGLE_WIRE   = sw_on;
  assign ERR_HI        = flag_r[7:4];
  assign ERR_LO        = flag_r[3:0];
  assign WAKE_FLAG     = wake_r;
  assign INT_REQ       = ev.out_valid || (wake_r && sys_r != can_mode_pkg::SYS_SLEEP);
  assign TXDOM_TMO     = txlock_r;
endmodule : can_mode_ctrl

// ---- tb/can_mode_ctrl_properties.sv ----
`timescale 1ns/10ps
// Port-level timing checks of the transceiver mode controller
module can_mode_ctrl_properties #(
  parameter int TXDOM_CYC = 20, // Stuck transmit limit
  parameter int LTMO_CYC  = 4   // Low-wire fault timeout
) (
  input wire logic       CLK,         // Clock
  input wire logic       RST,         // Sync reset
  input wire logic       TX_DOM,      // Transmit in
  input wire logic       RX_DOM,      // Receive out
  input wire logic       DIFF_DOM,    // Differential result
  input wire logic [7:0] FAIL_CMP,    // Fault comparators
  input wire logic       OVER_TEMP,   // Over-temperature
  input wire logic       PSUP_UV,     // Supply low
  input wire logic       MODE_WR,     // Mode write
  input wire logic [2:0] MODE_WDATA,  // Mode code
  input wire logic [7:0] FAIL_MASK,   // Interrupt enables
  input wire logic [1:0] XCVR_MODE,   // Mode out
  input wire logic [2:0] SYS_STATE,   // System mode
  input wire logic       H_DRV_EN,    // High driver
  input wire logic       L_DRV_EN,    // Low driver
  input wire logic       L_TERM_ON,   // Low termination
  input wire logic       SINGLE_WIRE, // Single wire
  input wire logic [3:0] ERR_LO,      // Flags 4..1
  input wire logic       INT_REQ,     // Interrupt
  input wire logic       TXDOM_TMO    // Stuck flag
);
  int tx_n;
  int l_n;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  // Run lengths of dominant transmit and low-wire ground fault
  always_ff @(posedge CLK)
  begin
    tx_n <= (RST || !TX_DOM) ? 0 : tx_n + 1;
    l_n  <= (RST || !FAIL_CMP[3]) ? 0 : l_n + 1;
  end
  AST_RX_DIFF : assert property (
    XCVR_MODE == can_mode_pkg::XCVR_FULL && FAIL_CMP == 8'h00 && !SINGLE_WIRE
    |=> RX_DOM == $past(DIFF_DOM)) else $error("receive not following bus");
  AST_RXO_ECHO : assert property (
    XCVR_MODE == can_mode_pkg::XCVR_RXO && TX_DOM |=> RX_DOM) else $error("no echo");
  AST_DRV_OFF : assert property (
    XCVR_MODE != can_mode_pkg::XCVR_FULL |-> !H_DRV_EN && !L_DRV_EN)
    else $error("driver on outside full mode");
  AST_MODE_TAKE : assert property (
    MODE_WR && MODE_WDATA inside {3'h1, 3'h2} && SYS_STATE == can_mode_pkg::SYS_NORM
    && !PSUP_UV |=> XCVR_MODE == can_mode_pkg::XCVR_FULL) else $error("mode write lost");
  AST_NORM_ONLY : assert property (
    SYS_STATE != can_mode_pkg::SYS_NORM [*2] |-> XCVR_MODE == can_mode_pkg::XCVR_STBY)
    else $error("active outside normal");
  AST_UV_STBY : assert property (
    PSUP_UV [*3] |-> XCVR_MODE == can_mode_pkg::XCVR_STBY) else $error("active in undervoltage");
  AST_HOT_OFF : assert property (
    OVER_TEMP [*3] |-> !H_DRV_EN && !L_DRV_EN) else $error("driver on while hot");
  AST_TX_STUCK : assert property (
    tx_n > TXDOM_CYC + 2 |-> !H_DRV_EN && !L_DRV_EN && TXDOM_TMO)
    else $error("stuck transmit not cut off");
  AST_L_FAULT : assert property (
    l_n > LTMO_CYC + 2 |-> !L_DRV_EN && !L_TERM_ON) else $error("low wire not released");
  AST_FAIL_INT : assert property (
    $rose(ERR_LO[0]) && FAIL_MASK[0] |-> ##[0:2] INT_REQ) else $error("no interrupt");
endmodule : can_mode_ctrl_properties

// ---- tb/can_bus_model.sv ----
`timescale 1ns/10ps
// Protocol controller and two-wire bus as seen by the transceiver
module can_bus_model (
  input  wire logic       tx_req,    // Controller wants dominant
  input  wire logic       drv_on,    // Node drivers enabled
  input  wire logic       far_dom,   // Another node dominant
  input  wire logic [7:0] fault,     // Wiring faults, bit n-1
  output logic            tx_dom,    // Transmit pin
  output logic            diff_dom,  // Differential result
  output logic            h_dom,     // High-wire result
  output logic            below_rec, // Differential recessive
  output logic [7:0]      fail_cmp,  // Fault comparators
  output logic            wake_h,    // High wake line
  output logic            wake_l     // Low wake line
);
  logic bus_dom;
  logic l_stuck;
  // Wired-or bus; a grounded or shorted low wire pins the differential result dominant
  assign bus_dom   = far_dom || (tx_req && drv_on);
  assign l_stuck   = fault[3] || fault[6];
  assign tx_dom    = tx_req;
  assign diff_dom  = bus_dom || l_stuck;
  assign h_dom     = bus_dom;
  assign below_rec = !diff_dom;
  assign fail_cmp  = fault;
  assign wake_h    = bus_dom;
  assign wake_l    = bus_dom;
endmodule : can_bus_model

// ---- tb/can_mode_ctrl_tb.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
`define WAITC(c) begin k = 0; while (!(c) && k < 60) begin @(posedge CLK); k++; end end
module can_mode_ctrl_tb;
  logic       CLK, RST, ctl_tx, far_dom, OVER_TEMP, PSUP_UV, MODE_WR, FLAG_RD, WAKE_RD;
  logic       TX_DOM, RX_DOM, DIFF_DOM, H_DOM, DIFF_BELOW_REC, WAKE_H, WAKE_L, INT_REQ;
  logic       H_DRV_EN, L_DRV_EN, H_TERM_GND_ON, L_TERM_ON, SINGLE_WIRE, WAKE_FLAG, TXDOM_TMO;
  logic [7:0] fault, FAIL_CMP, FAIL_MASK, err;
  logic [2:0] MODE_WDATA, SYS_MODE, SYS_STATE;
  logic [1:0] XCVR_MODE;
  logic [3:0] ERR_HI, ERR_LO;
  logic [2:0] codes [6] = '{3'h1, 3'h3, 3'h2, 3'h0, 3'h4, 3'h5};
  logic [1:0] xm [6]    = '{2'h1, 2'h2, 2'h1, 2'h0, 2'h2, 2'h0};
  int         mismatches, n_tests, cyc, k, i;
  assign err = {ERR_HI, ERR_LO};
  // Device with short filter counts, and the far side
  can_mode_ctrl #(.TXDOM_CYC(20), .DET_CYC(4), .REC_CYC(4), .WAKE_CYC(4), .LTMO_CYC(4))
  u_dut (.CLK(CLK), .RST(RST), .TX_DOM(TX_DOM), .RX_DOM(RX_DOM), .DIFF_DOM(DIFF_DOM),
    .H_DOM(H_DOM), .DIFF_BELOW_REC(DIFF_BELOW_REC), .FAIL_CMP(FAIL_CMP), .WAKE_H(WAKE_H),
    .WAKE_L(WAKE_L), .OVER_TEMP(OVER_TEMP), .PSUP_UV(PSUP_UV), .MODE_WR(MODE_WR),
    .MODE_WDATA(MODE_WDATA), .SYS_MODE(SYS_MODE), .FLAG_RD(FLAG_RD), .WAKE_RD(WAKE_RD),
    .FAIL_MASK(FAIL_MASK), .XCVR_MODE(XCVR_MODE), .SYS_STATE(SYS_STATE), .H_DRV_EN(H_DRV_EN),
    .L_DRV_EN(L_DRV_EN), .H_TERM_GND_ON(H_TERM_GND_ON), .L_TERM_ON(L_TERM_ON),
    .SINGLE_WIRE(SINGLE_WIRE), .ERR_HI(ERR_HI), .ERR_LO(ERR_LO), .WAKE_FLAG(WAKE_FLAG),
    .INT_REQ(INT_REQ), .TXDOM_TMO(TXDOM_TMO));
  can_bus_model u_bus (.tx_req(ctl_tx), .drv_on(H_DRV_EN || L_DRV_EN), .far_dom(far_dom),
    .fault(fault), .tx_dom(TX_DOM), .diff_dom(DIFF_DOM), .h_dom(H_DOM),
    .below_rec(DIFF_BELOW_REC), .fail_cmp(FAIL_CMP), .wake_h(WAKE_H), .wake_l(WAKE_L));
  // Clock and hang guard
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask : tick
  task automatic do_reset;
    RST <= 1'b1;
    tick(5);
    RST <= 1'b0;
    tick(1);
  endtask : do_reset
  task automatic set_mode(input logic [2:0] c);
    MODE_WR <= 1'b1;
    MODE_WDATA <= c;
    tick(1);
    MODE_WR <= 1'b0;
    tick(1);
  endtask : set_mode
  task automatic read_flags;
    FLAG_RD <= 1'b1;
    tick(1);
    FLAG_RD <= 1'b0;
    tick(1);
  endtask : read_flags
  // Main sequence
  initial
  begin
    {RST, ctl_tx, far_dom, OVER_TEMP, PSUP_UV, MODE_WR, FLAG_RD, WAKE_RD} = 8'h80;
    fault = 8'h00;
    FAIL_MASK = 8'hff;
    MODE_WDATA = 3'h0;
    SYS_MODE = 3'h0;
    do_reset();
    `CHK(XCVR_MODE, 2'h0)
    `CHK(SYS_STATE, 3'h0)
    `CHK({H_DRV_EN, L_DRV_EN, H_TERM_GND_ON, L_TERM_ON}, 4'h3)
    for (i = 0; i < 5; i++)
    begin
      SYS_MODE <= 3'(i);
      tick(2);
      set_mode(3'h1);
      `CHK(SYS_STATE, 3'(i))
      `CHK(XCVR_MODE, (i == 1) ? 2'h1 : 2'h0)
    end
    SYS_MODE <= 3'h1;
    do_reset();
    tick(2);
    for (i = 0; i < 6; i++)
    begin
      set_mode(codes[i]);
      `CHK(XCVR_MODE, xm[i])
      `CHK(H_DRV_EN && L_DRV_EN, xm[i] == 2'h1)
    end
    // Receive echo, then differential reception
    set_mode(3'h3);
    ctl_tx <= 1'b1;
    tick(2);
    `CHK(RX_DOM, 1'b1)
    ctl_tx <= 1'b0;
    set_mode(3'h1);
    far_dom <= 1'b1;
    tick(2);
    `CHK(RX_DOM, 1'b1)
    far_dom <= 1'b0;
    tick(2);
    `CHK(RX_DOM, 1'b0)
    // Short trip is filtered out, then all eight faults queue events
    fault <= 8'h04;
    tick(2);
    fault <= 8'h00;
    tick(8);
    `CHK(ERR_LO[2], 1'b0)
    for (i = 0; i < 8; i++)
    begin
      fault[i] <= 1'b1;
      `WAITC(err[i])
      `CHK(err[i], 1'b1)
      `CHK(INT_REQ, 1'b1)
      if (i == 2)
        `CHK(SINGLE_WIRE, 1'b1)
    end
    `CHK({H_DRV_EN, L_DRV_EN, H_TERM_GND_ON, L_TERM_ON}, 4'h0)
    fault <= 8'h00;
    tick(30);
    `CHK(err, 8'hff)
    for (i = 0; i < 8; i++)
    begin
      `CHK(INT_REQ, 1'b1)
      read_flags();
    end
    `CHK(INT_REQ, 1'b0)
    `CHK(err, 8'h00)
    FAIL_MASK <= 8'h00;
    fault <= 8'h01;
    `WAITC(err[0])
    tick(2);
    `CHK(INT_REQ, 1'b0)
    fault <= 8'h00;
    FAIL_MASK <= 8'hff;
    read_flags();
    // Stuck transmit, then over-temperature
    ctl_tx <= 1'b1;
    tick(40);
    `CHK({H_DRV_EN, TXDOM_TMO}, 2'h1)
    ctl_tx <= 1'b0;
    tick(3);
    `CHK(H_DRV_EN, 1'b1)
    OVER_TEMP <= 1'b1;
    far_dom <= 1'b1;
    tick(4);
    `CHK({H_DRV_EN, L_DRV_EN, RX_DOM}, 3'h1)
    {OVER_TEMP, far_dom} <= 2'h0;
    // Supply undervoltage forces stand-by, which persists
    PSUP_UV <= 1'b1;
    tick(3);
    `CHK(XCVR_MODE, 2'h0)
    set_mode(3'h1);
    `CHK(XCVR_MODE, 2'h0)
    PSUP_UV <= 1'b0;
    tick(3);
    `CHK(XCVR_MODE, 2'h0)
    // Bus wake: glitch rejected, held level recorded, sleep exits
    far_dom <= 1'b1;
    tick(2);
    far_dom <= 1'b0;
    tick(6);
    `CHK(WAKE_FLAG, 1'b0)
    far_dom <= 1'b1;
    tick(10);
    far_dom <= 1'b0;
    `CHK(WAKE_FLAG, 1'b1)
    WAKE_RD <= 1'b1;
    tick(1);
    WAKE_RD <= 1'b0;
    tick(1);
    `CHK(WAKE_FLAG, 1'b0)
    SYS_MODE <= 3'h3;
    tick(3);
    far_dom <= 1'b1;
    `WAITC(SYS_STATE == 3'h0)
    `CHK(SYS_STATE, 3'h0)
    wrap_up();
  end
endmodule : can_mode_ctrl_tb
bind can_mode_ctrl can_mode_ctrl_properties #(.TXDOM_CYC(TXDOM_CYC), .LTMO_CYC(LTMO_CYC))
u_chk (.CLK(CLK), .RST(RST), .TX_DOM(TX_DOM), .RX_DOM(RX_DOM), .DIFF_DOM(DIFF_DOM),
  .FAIL_CMP(FAIL_CMP), .OVER_TEMP(OVER_TEMP), .PSUP_UV(PSUP_UV), .MODE_WR(MODE_WR),
  .MODE_WDATA(MODE_WDATA), .FAIL_MASK(FAIL_MASK), .XCVR_MODE(XCVR_MODE), .SYS_STATE(SYS_STATE),
  .H_DRV_EN(H_DRV_EN), .L_DRV_EN(L_DRV_EN), .L_TERM_ON(L_TERM_ON), .SINGLE_WIRE(SINGLE_WIRE),
  .ERR_LO(ERR_LO), .INT_REQ(INT_REQ), .TXDOM_TMO(TXDOM_TMO));
